// ==== src/wake_gate_consts.svh ====
// Purpose: Named offsets, reset values and field positions for the wake gating block
// Assumes: Included by bare name from design files
// Notes: Definitions only
`ifndef WAKE_GATE_CONSTS_SVH
`define WAKE_GATE_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_STATUS_PERIPH 8'h04
`define OFS_STATUS_GRP1 8'h05
`define OFS_STATUS_GRP2 8'h06
`define OFS_STATUS_GRP3 8'h07
`define OFS_ENABLE_PERIPH 8'h0A
`define OFS_ENABLE_GRP1 8'h0B
`define OFS_ENABLE_GRP2 8'h0C
`define OFS_ENABLE_GRP3 8'h0D
`define OFS_MASTER_CTRL 8'h20

// ****************************************
// Reset values and fields
// ****************************************
`define ENABLE_RESET 8'h00
`define STATUS_RESET 8'h00
`define READ_ZERO 8'h00
`define PERIPH_RSVD_MASK 8'hFE
`define GRP_FULL_MASK 8'hFF
`define MASTER_BIT 0
`define NUM_GROUPS 4

`endif

// ==== src/wake_gate_pkg.sv ====
// Purpose: Types shared by the wake gating block
// Assumes: Constants come from wake_gate_consts.svh
// Notes: Types only
package wake_gate_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] group_idx_t;
endpackage : wake_gate_pkg

// ==== src/wake_status_group.sv ====
// Purpose: One group of eight sticky wake status bits with its enable gate
// Assumes: Events are synchronised single-clock level or pulse inputs
// Notes: Set wins over a write-one clear in the same cycle
`timescale 1ns/1ps
`include "wake_gate_consts.svh"
module wake_status_group
    import wake_gate_pkg::*;
#(
    parameter byte_t VALID_MASK = 8'hFF
) (
    input wire logic clock,
    input wire logic standby_por,
    input wire logic [7:0] event_in,
    input wire logic clear_write,
    input wire logic [7:0] clear_data,
    input wire logic [7:0] enable,
    output logic [7:0] status,
    output logic gated_any
);
    // ****************************************
    // Sticky status
    // ****************************************
    wire logic [7:0] next_status;
    // Write one clears, event set takes precedence
    assign next_status = ((status & ~(clear_write ? clear_data : `READ_ZERO)) | event_in) & VALID_MASK;

    // Only the standby rail reset clears status
    always_ff @(posedge clock) begin
        if (standby_por) begin
            status <= `STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // Disabled bits never reach the output
    assign gated_any = |(status & enable);

    a_set_beats_clear: assert property (@(posedge clock) disable iff (standby_por)
        (event_in[0] && VALID_MASK[0]) |=> status[0]) else $error("status bit 0 missed event");
    a_clear_one_only: assert property (@(posedge clock) disable iff (standby_por)
        (clear_write && !clear_data[1] && status[1]) |=> status[1]) else $error("zero write cleared bit");
    a_clear_takes: assert property (@(posedge clock) disable iff (standby_por)
        (clear_write && clear_data[2] && !event_in[2]) |=> !status[2]) else $error("write one did not clear");
endmodule : wake_status_group

// ==== src/wake_event_enable_gating.sv ====
// Purpose: Per-source gating of wake events onto the shared active-low wake output
// Assumes: Event inputs arrive from pins and are synchronised here; srst is the standby rail reset
// Notes: Main supply, soft and hard resets are not seen by this block at all
`timescale 1ns/1ps
`include "wake_gate_consts.svh"

// Notes on behaviour
// - A source drives the wake output only when its enable, its status and the master enable are all one.
// - A disabled source still records its event in status but cannot drive the wake output.
// - Enable registers clear to zero only on the standby rail reset and survive every other reset.
// - Peripheral enable bits are reserved, ring two, ring one, keyboard, pointer, key, fan one, fan two.
// - Group one enable bits 0 to 7 cover pins 10 to 17 in ascending order.
// - Group two bits 0-2 cover pins 20-22, bit 3 the grouped interrupt wake, bits 4-7 pins 24-27.
// - Group three bits 0 to 7 cover pins 30, 31, 32, 33, 41, 43, 60 and 61.
// - Each status bit except reserved peripheral bit 0 sets on its event regardless of the enables.
// - Writing one clears a status bit and writing zero leaves it.
module wake_event_enable_gating
    import wake_gate_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [7:0] periph_events,
    input wire logic [7:0] pin_group_one_events,
    input wire logic [7:0] pin_group_two_events,
    input wire logic [7:0] pin_group_three_events,
    output logic shared_wake_output_n
);
    // ****************************************
    // Event synchronisers
    // ****************************************
    logic [31:0] sync_a;
    logic [31:0] sync_b;
    wire logic [31:0] raw_events;
    assign raw_events = {pin_group_three_events, pin_group_two_events, pin_group_one_events, periph_events};

    // Two flops per pin; only sync_b is used downstream
    always_ff @(posedge clock) begin
        sync_a <= raw_events;
        sync_b <= sync_a;
    end

    // ****************************************
    // Register decode
    // ****************************************
    byte_t enable_reg [`NUM_GROUPS];
    logic wake_master_enable;
    wire logic [7:0] status_bits [`NUM_GROUPS];
    wire logic [3:0] gated_grp;
    wire logic [7:0] enable_ofs [`NUM_GROUPS];
    wire logic [7:0] status_ofs [`NUM_GROUPS];
    wire byte_t valid_mask [`NUM_GROUPS];

    assign enable_ofs[0] = `OFS_ENABLE_PERIPH;
    assign enable_ofs[1] = `OFS_ENABLE_GRP1;
    assign enable_ofs[2] = `OFS_ENABLE_GRP2;
    assign enable_ofs[3] = `OFS_ENABLE_GRP3;
    assign status_ofs[0] = `OFS_STATUS_PERIPH;
    assign status_ofs[1] = `OFS_STATUS_GRP1;
    assign status_ofs[2] = `OFS_STATUS_GRP2;
    assign status_ofs[3] = `OFS_STATUS_GRP3;
    // Peripheral bit 0 is reserved; groups map bit n to their n-th source
    assign valid_mask[0] = `PERIPH_RSVD_MASK;
    assign valid_mask[1] = `GRP_FULL_MASK;
    assign valid_mask[2] = `GRP_FULL_MASK;
    assign valid_mask[3] = `GRP_FULL_MASK;

    wire logic master_hit;
    assign master_hit = (addr == `OFS_MASTER_CTRL);

    // ****************************************
    // Per-group enable registers and status
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `NUM_GROUPS; g++) begin : grp
            wire logic en_hit;
            wire logic st_hit;
            assign en_hit = wr && (addr == enable_ofs[g]);
            assign st_hit = wr && (addr == status_ofs[g]);

            // Cleared only by the standby rail reset
            // Bits map one to one onto source event positions
            always_ff @(posedge clock) begin
                if (srst) begin
                    enable_reg[g] <= `ENABLE_RESET;
                end else if (en_hit) begin
                    enable_reg[g] <= wdata & valid_mask[g];
                end
            end

            // Event bit n pairs with enable bit n in each group
            // Masking is done on the event_in connection below, so every group instance is full width
            wake_status_group #(
                .VALID_MASK(`GRP_FULL_MASK)
            ) u_status (
                .clock(clock),
                .standby_por(srst),
                .event_in(sync_b[g*8 +: 8] & valid_mask[g]),
                .clear_write(st_hit),
                .clear_data(wdata),
                .enable(enable_reg[g]),
                .status(status_bits[g]),
                .gated_any(gated_grp[g])
            );

            a_group_gate_pin: assert property (@(posedge clock) disable iff (srst)
                (wake_master_enable && gated_grp[g]) |=> !shared_wake_output_n)
                else $error("enabled pending group did not drive wake");
        end
    endgenerate

    // Master enable, standby-rail reset like the enables
    always_ff @(posedge clock) begin
        if (srst) begin
            wake_master_enable <= 1'b0;
        end else if (wr && master_hit) begin
            wake_master_enable <= wdata[`MASTER_BIT];
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = `READ_ZERO;
        for (int i = 0; i < `NUM_GROUPS; i++) begin
            if (addr == enable_ofs[i]) begin
                next_rdata = enable_reg[i];
            end
            if (addr == status_ofs[i]) begin
                next_rdata = status_bits[i];
            end
        end
        if (master_hit) begin
            next_rdata = {7'h00, wake_master_enable};
        end
    end

    // Data valid only in the cycle after the strobe; zero otherwise
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata <= `READ_ZERO;
        end else begin
            rdata <= rd ? next_rdata : `READ_ZERO;
        end
    end

    // ****************************************
    // Wake output
    // ****************************************
    // All three conditions needed per source
    // Registered so the pin never glitches
    always_ff @(posedge clock) begin
        if (srst) begin
            shared_wake_output_n <= 1'b1;
        end else begin
            shared_wake_output_n <= ~(wake_master_enable && (|gated_grp));
        end
    end

    a_wake_follows_cause: assert property (@(posedge clock) disable iff (srst)
        (wake_master_enable && |gated_grp) |=> !shared_wake_output_n) else $error("wake not asserted");
    a_wake_needs_master: assert property (@(posedge clock) disable iff (srst)
        !wake_master_enable |=> shared_wake_output_n) else $error("wake without master enable");
    a_disabled_silent: assert property (@(posedge clock) disable iff (srst)
        (enable_reg[0] == 8'h00 && enable_reg[1] == 8'h00 && enable_reg[2] == 8'h00 && enable_reg[3] == 8'h00)
        |=> shared_wake_output_n) else $error("wake with all sources disabled");
    a_enable_write_lands: assert property (@(posedge clock) disable iff (srst)
        (wr && addr == `OFS_ENABLE_GRP1) |=> enable_reg[1] == $past(wdata)) else $error("enable write lost");
    a_periph_rsvd_zero: assert property (@(posedge clock) disable iff (srst)
        1'b1 |-> !enable_reg[0][0] && !status_bits[0][0]) else $error("reserved bit set");
    a_enable_reset_zero: assert property (@(posedge clock)
        srst |=> enable_reg[2] == 8'h00 && enable_reg[3] == 8'h00) else $error("enable not reset");
    a_event_two_flops: assert property (@(posedge clock) disable iff (srst)
        pin_group_three_events[7] ##1 pin_group_three_events[7] |=> ##1 status_bits[3][7])
        else $error("group three event not recorded");
    a_grouped_irq_bit: assert property (@(posedge clock) disable iff (srst)
        (wr && addr == `OFS_ENABLE_GRP2) |=> enable_reg[2][3] == $past(wdata[3])) else $error("grouped irq enable lost");

    // ****************************************
    // Register and output checks
    // ****************************************
    // A source held two cycles; the two flops pass a one-cycle pulse as well
    sequence s_pin_held;
        pin_group_three_events[0] ##1 pin_group_three_events[0];
    endsequence

    a_pin_thirty_seen: assert property (@(posedge clock) disable iff (srst)
        s_pin_held |=> ##1 status_bits[3][0]) else $error("group three bit 0 not recorded");

    a_master_write_lands: assert property (@(posedge clock) disable iff (srst)
        (wr && master_hit) |=> wake_master_enable == $past(wdata[`MASTER_BIT])) else $error("master write lost");

    a_enable_holds: assert property (@(posedge clock) disable iff (srst)
        !wr |=> $stable(enable_reg[1]) && $stable(enable_reg[3])) else $error("enable changed without write");

    a_enable_read_back: assert property (@(posedge clock) disable iff (srst)
        (rd && addr == `OFS_ENABLE_PERIPH) |=> rdata == $past(enable_reg[0])) else $error("enable read wrong");

    a_status_read_back: assert property (@(posedge clock) disable iff (srst)
        (rd && addr == `OFS_STATUS_GRP3) |=> rdata == $past(status_bits[3])) else $error("status read wrong");

    a_wake_release: assert property (@(posedge clock) disable iff (srst)
        !(wake_master_enable && |gated_grp) |=> shared_wake_output_n) else $error("wake held without cause");

    // Grouped interrupt gate, a wake source like any pin
    a_grouped_irq_gate: assert property (@(posedge clock) disable iff (srst)
        (wake_master_enable && enable_reg[2][3] && status_bits[2][3]) |=> !shared_wake_output_n)
        else $error("grouped interrupt did not wake");
endmodule : wake_event_enable_gating

// ==== dv/wake_sink.sv ====
// Purpose: Far-side wake input that counts wake requests
// Assumes: Wake line is active low and registered by the block
// Notes: Counts high-to-low changes only
`timescale 1ns/1ps
// ****************************************
// Wake receiver
// ****************************************
module wake_sink (
    input wire logic clock,
    input wire logic srst,
    input wire logic wake_n,
    output int falls
);
    logic last_n;
    // Sampled on the clock, as the line is registered and glitch free
    always_ff @(posedge clock) begin
        last_n <= wake_n;
        if (srst) begin
            falls <= 0;
        end else if (last_n && !wake_n) begin
            falls <= falls + 1;
        end
    end
endmodule : wake_sink

// ==== dv/wake_event_enable_gating_tb.sv ====
// Purpose: Register and wake gating tests for the wake block
// Assumes: Status at 0x04-0x07, master enable at 0x20 bit 0
// Notes: Events are two-cycle pulses on a flat 32-bit vector
`timescale 1ns/1ps
`include "wake_gate_consts.svh"
// ****************************************
// Testbench
// ****************************************
module wake_event_enable_gating_tb import wake_gate_pkg::*;;
    logic clock = 0, srst = 1, wr = 0, rd = 0, wake_n;
    byte_t addr = 8'h00, wdata = 8'h00, rdata, m;
    logic [31:0] ev = 32'h0;
    int falls, err_total = 0, n_tests = 0, cyc = 0;

    wake_event_enable_gating dut (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .periph_events(ev[7:0]), .pin_group_one_events(ev[15:8]),
        .pin_group_two_events(ev[23:16]), .pin_group_three_events(ev[31:24]), .shared_wake_output_n(wake_n));
    wake_sink sink (.clock(clock), .srst(srst), .wake_n(wake_n), .falls(falls));

    // Clock and hang guard; the tests need well under 2000 cycles
    initial forever #10 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            give_verdict();
        end
    end

    task chk(input byte_t seen, input byte_t exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task wr_reg(input byte_t a, input byte_t d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task rd_reg(input byte_t a, output byte_t d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_cyc
    task pulse(input int i);
        @(posedge clock);
        ev[i] <= 1'b1;
        repeat (2) @(posedge clock);
        ev[i] <= 1'b0;
    endtask : pulse
    task give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        for (int g = 0; g < 4; g++) begin
            rd_reg(byte_t'(`OFS_ENABLE_PERIPH + g), m);
            chk(m, `ENABLE_RESET);
            wr_reg(byte_t'(`OFS_ENABLE_PERIPH + g), 8'hFF);
            rd_reg(byte_t'(`OFS_ENABLE_PERIPH + g), m);
            chk(m, (g == 0) ? `PERIPH_RSVD_MASK : `GRP_FULL_MASK);
        end
        wr_reg(8'h0F, 8'hFF);
        rd_reg(8'h0F, m);
        chk(m, `READ_ZERO);
        $display("test enable registers done");
        // Every source in turn, all enables on, bit 0 reserved
        wr_reg(`OFS_MASTER_CTRL, 8'h01);
        for (int i = 0; i < 32; i++) begin
            pulse(i);
            wait_cyc(6);
            rd_reg(byte_t'(`OFS_STATUS_PERIPH + i / 8), m);
            chk(m, (i == 0) ? 8'h00 : byte_t'(1 << (i % 8)));
            chk({7'h0, wake_n}, {7'h0, i == 0});
            wr_reg(byte_t'(`OFS_STATUS_PERIPH + i / 8), 8'h00);
            rd_reg(byte_t'(`OFS_STATUS_PERIPH + i / 8), m);
            chk(m, (i == 0) ? 8'h00 : byte_t'(1 << (i % 8)));
            wr_reg(byte_t'(`OFS_STATUS_PERIPH + i / 8), byte_t'(1 << (i % 8)));
            wait_cyc(3);
            chk({7'h0, wake_n}, 8'h01);
        end
        chk(byte_t'(falls), 8'h1F);
        $display("test source mapping done");
        // Disabled source still records but stays off the line
        wr_reg(`OFS_ENABLE_GRP1, 8'h00);
        pulse(11);
        wait_cyc(6);
        rd_reg(`OFS_STATUS_GRP1, m);
        chk(m, 8'h08);
        chk({7'h0, wake_n}, 8'h01);
        wr_reg(`OFS_ENABLE_GRP1, 8'hFF);
        wr_reg(`OFS_MASTER_CTRL, 8'h00);
        wait_cyc(3);
        chk({7'h0, wake_n}, 8'h01);
        wr_reg(`OFS_MASTER_CTRL, 8'h01);
        wait_cyc(3);
        chk({7'h0, wake_n}, 8'h00);
        $display("test gating done");
        // Second standby reset clears the enables
        @(posedge clock);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        for (int g = 0; g < 4; g++) begin
            rd_reg(byte_t'(`OFS_ENABLE_PERIPH + g), m);
            chk(m, `ENABLE_RESET);
        end
        chk({7'h0, wake_n}, 8'h01);
        $display("test second reset done");
        give_verdict();
    end
endmodule : wake_event_enable_gating_tb
